// file: src/bus_target.v
`timescale 1ns/1ps
`include "bus_layer_consts.vh"
module bus_target #(
	parameter STARTUP_CYCLES = `STARTUP_MS * `CLK_KHZ
) (
	// Clock and reset
	input wire clk_sys_in,
	input wire reset_n_in,
	// Clock line, open drain
	input wire scl_in,
	output reg scl_out,
	output reg scl_oe_n_out,
	// Data line, open drain
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe_n_out,
	// Command and data side
	input wire [7:0] tx_data_in,
	input wire measuring_in,
	output reg [7:0] rx_data_out,
	output reg rx_valid_out,
	output reg addr_match_out,
	output reg read_mode_out,
	output reg tx_taken_out,
	output reg master_nack_out,
	// Bus status
	output reg start_out,
	output reg stop_out,
	output reg busy_out,
	output reg ready_out,
	output reg sleep_out
);

localparam [6:0] ST_IDLE = 7'h01;
localparam [6:0] ST_ADDR = 7'h02;
localparam [6:0] ST_RX = 7'h04;
localparam [6:0] ST_ACK = 7'h08;
localparam [6:0] ST_TX = 7'h10;
localparam [6:0] ST_TXACK = 7'h20;
// Not addressed or master refused: wait for start or stop
localparam [6:0] ST_WAIT = 7'h40;

// Full-width count first, then cut on purpose to the counter width
localparam [31:0] STARTUP_LAST_FULL = STARTUP_CYCLES - 1;
localparam [`STARTUP_CNT_W-1:0] STARTUP_LAST = STARTUP_LAST_FULL[`STARTUP_CNT_W-1:0];

wire scl_lvl;
wire scl_prev;
wire scl_rise;
wire scl_fall;
wire sda_lvl;
wire sda_prev;
wire sda_rise;
wire sda_fall;

reg [6:0] state;
reg [3:0] bit_cnt;
reg [7:0] rx_shift;
reg [7:0] tx_shift;
reg from_addr;
reg master_ack;
reg [`STARTUP_CNT_W-1:0] startup_cnt;

wire scl_stable_high;
wire start_seen;
wire stop_seen;

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

line_sync u_scl_sync (
	.clk_sys_in(clk_sys_in),
	.reset_n_in(reset_n_in),
	.pin_in(scl_in),
	.level_out(scl_lvl),
	.prev_out(scl_prev),
	.rise_out(scl_rise),
	.fall_out(scl_fall)
);

line_sync u_sda_sync (
	.clk_sys_in(clk_sys_in),
	.reset_n_in(reset_n_in),
	.pin_in(sda_in),
	.level_out(sda_lvl),
	.prev_out(sda_prev),
	.rise_out(sda_rise),
	.fall_out(sda_fall)
);

// Clock must be high in both samples around the data edge
assign scl_stable_high = scl_lvl & scl_prev;
assign start_seen = ready_out & scl_stable_high & sda_fall;
assign stop_seen = ready_out & scl_stable_high & sda_rise;

// Data bit to open-drain enable: a one releases the line
function drive_bit;
	input bit_val;
	begin
		drive_bit = bit_val;
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Power-up delay: the count only advances while the clock line is high

always @(posedge clk_sys_in or negedge reset_n_in) begin
	if (!reset_n_in) begin
		startup_cnt <= {`STARTUP_CNT_W{1'b0}};
		ready_out <= 1'b0;
	end else if (!ready_out && scl_lvl) begin
		if (startup_cnt == STARTUP_LAST) begin
			ready_out <= 1'b1;
		end else begin
			startup_cnt <= startup_cnt + 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Bus protocol
// No timeout anywhere: state only moves on line events, so any clock period works

always @(posedge clk_sys_in or negedge reset_n_in) begin
	if (!reset_n_in) begin
		state <= ST_IDLE;
		bit_cnt <= `BIT_COUNT_ZERO;
		rx_shift <= 8'h00;
		tx_shift <= 8'h00;
		from_addr <= 1'b0;
		master_ack <= 1'b0;
		sda_out <= 1'b0;
		sda_oe_n_out <= 1'b1;
		rx_data_out <= 8'h00;
		rx_valid_out <= 1'b0;
		addr_match_out <= 1'b0;
		read_mode_out <= 1'b0;
		tx_taken_out <= 1'b0;
		master_nack_out <= 1'b0;
		start_out <= 1'b0;
		stop_out <= 1'b0;
		busy_out <= 1'b0;
	end else begin
		rx_valid_out <= 1'b0;
		tx_taken_out <= 1'b0;
		master_nack_out <= 1'b0;
		start_out <= start_seen;
		stop_out <= stop_seen;
		if (start_seen) begin
			// Repeated start also lands here and restarts the header
			state <= ST_ADDR;
			busy_out <= 1'b1;
			bit_cnt <= `BIT_COUNT_ZERO;
			addr_match_out <= 1'b0;
			sda_oe_n_out <= 1'b1;
		end else if (stop_seen) begin
			state <= ST_IDLE;
			busy_out <= 1'b0;
			addr_match_out <= 1'b0;
			read_mode_out <= 1'b0;
			sda_oe_n_out <= 1'b1;
		end else begin
			case (state)
			ST_ADDR, ST_RX: begin
				if (scl_rise) begin
					rx_shift <= {rx_shift[6:0], sda_lvl};
					bit_cnt <= bit_cnt + `BIT_COUNT_ONE;
				end else if (scl_fall && bit_cnt == `BITS_PER_BYTE) begin
					if (state == ST_RX) begin
						rx_data_out <= rx_shift;
						rx_valid_out <= 1'b1;
						sda_oe_n_out <= 1'b0;
						from_addr <= 1'b0;
						state <= ST_ACK;
					end else if (rx_shift[7:1] == `TARGET_ADDR) begin
						addr_match_out <= 1'b1;
						read_mode_out <= (rx_shift[0] == `DIR_READ);
						sda_oe_n_out <= 1'b0;
						from_addr <= 1'b1;
						state <= ST_ACK;
					end else begin
						state <= ST_WAIT;
					end
				end
			end
			ST_ACK: begin
				if (scl_fall) begin
					bit_cnt <= `BIT_COUNT_ZERO;
					if (from_addr && read_mode_out) begin
						tx_shift <= tx_data_in;
						tx_taken_out <= 1'b1;
						sda_oe_n_out <= drive_bit(tx_data_in[7]);
						state <= ST_TX;
					end else begin
						sda_oe_n_out <= 1'b1;
						state <= ST_RX;
					end
				end
			end
			ST_TX: begin
				if (scl_rise) begin
					bit_cnt <= bit_cnt + `BIT_COUNT_ONE;
				end else if (scl_fall) begin
					if (bit_cnt == `BITS_PER_BYTE) begin
						sda_oe_n_out <= 1'b1;
						state <= ST_TXACK;
					end else begin
						// Each bit holds from one falling edge to the next
						tx_shift <= {tx_shift[6:0], 1'b0};
						sda_oe_n_out <= drive_bit(tx_shift[6]);
					end
				end
			end
			ST_TXACK: begin
				if (scl_rise) begin
					master_ack <= ~sda_lvl;
					if (sda_lvl) begin
						master_nack_out <= 1'b1;
					end
				end else if (scl_fall) begin
					bit_cnt <= `BIT_COUNT_ZERO;
					if (master_ack) begin
						tx_shift <= tx_data_in;
						tx_taken_out <= 1'b1;
						sda_oe_n_out <= drive_bit(tx_data_in[7]);
						state <= ST_TX;
					end else begin
						state <= ST_WAIT;
					end
				end
			end
			default: begin
				sda_oe_n_out <= 1'b1;
			end
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Clock stretching and sleep

// Only pulls the clock after the master has taken it low, so no glitch is cut short
always @(posedge clk_sys_in or negedge reset_n_in) begin
	if (!reset_n_in) begin
		scl_out <= 1'b0;
		scl_oe_n_out <= 1'b1;
		sleep_out <= 1'b0;
	end else begin
		if (!measuring_in) begin
			scl_oe_n_out <= 1'b1;
		end else if (addr_match_out && busy_out && scl_fall) begin
			scl_oe_n_out <= 1'b0;
		end
		sleep_out <= ready_out & ~busy_out & ~measuring_in;
	end
end

endmodule // bus_target

// file: src/bus_layer_consts.vh
`ifndef BUS_LAYER_CONSTS_VH
`define BUS_LAYER_CONSTS_VH

// Fixed target address shared by every instance
`define TARGET_ADDR 7'h4a
// Direction bit value meaning read
`define DIR_READ 1'b1
// Data bits per byte and the count that closes a byte
`define BITS_PER_BYTE 4'h8
`define BIT_COUNT_ZERO 4'h0
`define BIT_COUNT_ONE 4'h1
// Power-up time to idle, in milliseconds, and the clock rate in kHz
`define STARTUP_MS 15
`define CLK_KHZ 100000
// Startup counter width, wide enough for the default count
`define STARTUP_CNT_W 21

`endif

// file: src/line_sync.v
`timescale 1ns/1ps
module line_sync (
	// Clock and reset
	input wire clk_sys_in,
	input wire reset_n_in,
	// Raw pin level
	input wire pin_in,
	// Synchronised level, the sample before it, and edges
	output wire level_out,
	output wire prev_out,
	output wire rise_out,
	output wire fall_out
);

reg meta;
reg stable;
reg stable_d;

// Lines idle high through the pull-ups, so reset to high avoids false edges
always @(posedge clk_sys_in or negedge reset_n_in) begin
	if (!reset_n_in) begin
		meta <= 1'b1;
		stable <= 1'b1;
		stable_d <= 1'b1;
	end else begin
		meta <= pin_in;
		stable <= meta;
		stable_d <= stable;
	end
end

assign level_out = stable;
assign prev_out = stable_d;
assign rise_out = stable & ~stable_d;
assign fall_out = ~stable & stable_d;

endmodule // line_sync

// file: testbench/bus_target_props.sv
`timescale 1ns/1ps
module bus_target_props #(
	parameter STARTUP_CYCLES = 20
) (
	// Clock, reset and lines
	input wire clk_sys_in,
	input wire reset_n_in,
	input wire scl_in,
	input wire sda_in,
	input wire measuring_in,
	// Observed outputs
	input wire sda_oe_n_out,
	input wire scl_oe_n_out,
	input wire addr_match_out,
	input wire read_mode_out,
	input wire rx_valid_out,
	input wire start_out,
	input wire stop_out,
	input wire busy_out,
	input wire ready_out,
	input wire sleep_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);
	sequence quiet;
		ready_out && !busy_out && !measuring_in;
	endsequence
	sequence sda_drop;
		ready_out && scl_in && $fell(sda_in);
	endsequence
	sequence sda_lift;
		ready_out && scl_in && $rose(sda_in);
	endsequence
	start_seen_a: assert property (sda_drop |-> ##[2:6] start_out)
		else $error("start missed");
	stop_seen_a: assert property (sda_lift |-> ##[2:6] stop_out)
		else $error("stop missed");
	stop_frees_a: assert property (stop_out |=> !busy_out && !addr_match_out)
		else $error("bus not freed");
	idle_sleep_a: assert property (quiet ##1 quiet |-> sleep_out)
		else $error("no sleep");
	sda_low_phase_a: assert property ($changed(sda_oe_n_out) |-> !scl_in)
		else $error("data moved with clock high");
	header_ack_a: assert property ($rose(addr_match_out) |-> ##[0:2] !sda_oe_n_out)
		else $error("header not acked");
	byte_ack_a: assert property (rx_valid_out |-> !read_mode_out ##[0:3] !sda_oe_n_out)
		else $error("byte not acked");
	boot_quiet_a: assert property (!ready_out |-> sda_oe_n_out && scl_oe_n_out && !busy_out)
		else $error("active before ready");
	// Start pulse comes three samples after the data fall it was built from
	start_needs_high_a: assert property (start_out |->
		$past(scl_in, 3) && $past(scl_in, 4) && $past(sda_in, 4) && !$past(sda_in, 3))
		else $error("start without stable high clock");
endmodule // bus_target_props

bind bus_target bus_target_props #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_bus_target_props (.*);

// file: testbench/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
	// Clock and line levels
	input wire clk_sys_in,
	input wire scl_in,
	input wire sda_in,
	// Pulls, high means pull the line low
	output reg scl_pull_out,
	output reg sda_pull_out
);
	initial begin
		scl_pull_out = 0;
		sda_pull_out = 0;
	end
	task half;
		repeat (8) @(negedge clk_sys_in);
	endtask
	task pull_clock(input v);
		scl_pull_out = v;
	endtask
	// Release the clock and wait out a stretch by the target
	task high;
		integer n;
		begin
			scl_pull_out = 0;
			for (n = 0; n < 4000 && !scl_in; n = n + 1) @(negedge clk_sys_in);
			half;
		end
	endtask
	// Data moves one clock after the clock line falls, never with it
	task start;
		begin
			@(negedge clk_sys_in);
			sda_pull_out = 0;
			half;
			high;
			sda_pull_out = 1;
			half;
			scl_pull_out = 1;
		end
	endtask
	task stop;
		begin
			@(negedge clk_sys_in);
			sda_pull_out = 1;
			half;
			high;
			sda_pull_out = 0;
			half;
		end
	endtask
	// Nine clocks, MSB first; a 1 bit releases data for the target
	task xbyte(input [8:0] d, output [8:0] q);
		integer i;
		begin
			for (i = 8; i >= 0; i = i - 1) begin
				@(negedge clk_sys_in);
				sda_pull_out = !d[i];
				half;
				high;
				q[i] = sda_in;
				scl_pull_out = 1;
			end
		end
	endtask
endmodule // i2c_master_model

// file: testbench/sensor_i2c_target_bus_layer_tb_top.sv
`timescale 1ns/1ps
module sensor_i2c_target_bus_layer_tb_top;
	reg clk_sys_in = 0;
	reg reset_n_in = 0;
	reg measuring_in = 0;
	reg [7:0] tx_data_in = 8'h00;
	wire scl_oe_n, sda_oe_n, scl_m, sda_m, match, rmode, busy, ready, sleep;
	wire taken, nack, scl_o, sda_o;
	wire scl = !(scl_m || !scl_oe_n);
	wire sda = !(sda_m || !sda_oe_n);
	wire [7:0] rx_data;
	integer bad_count = 0;
	integer tests_run = 0;
	integer cyc = 0;
	integer taken_count = 0;
	integer nack_count = 0;
	reg [8:0] q;
	time t0;
	always #5 clk_sys_in = !clk_sys_in;
	bus_target #(.STARTUP_CYCLES(20)) u_bus_target (.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in), .scl_in(scl), .scl_out(scl_o), .scl_oe_n_out(scl_oe_n),
		.sda_in(sda), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .tx_data_in(tx_data_in),
		.measuring_in(measuring_in), .rx_data_out(rx_data), .rx_valid_out(),
		.addr_match_out(match), .read_mode_out(rmode), .tx_taken_out(taken),
		.master_nack_out(nack), .start_out(), .stop_out(), .busy_out(busy),
		.ready_out(ready), .sleep_out(sleep));
	i2c_master_model mst (.clk_sys_in(clk_sys_in), .scl_in(scl), .sda_in(sda),
		.scl_pull_out(scl_m), .sda_pull_out(sda_m));
	task chk(input [8:0] s, input [8:0] e);
		begin
			tests_run = tests_run + 1;
			if (s !== e) begin
				bad_count = bad_count + 1;
				$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
			end
		end
	endtask
	task give_verdict;
		begin
			$display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
			if (bad_count == 0 && tests_run > 0) begin
				$display("ALL CHECKS OK");
			end else begin
				$display("CHECKS NOT OK");
			end
			$finish;
		end
	endtask
	// Pulses last one clock, so the falling edge sees each exactly once
	always @(negedge clk_sys_in) begin
		if (taken === 1'b1) begin
			taken_count = taken_count + 1;
		end
		if (nack === 1'b1) begin
			nack_count = nack_count + 1;
		end
	end
	always @(posedge clk_sys_in) begin
		cyc = cyc + 1;
		if (cyc == 10000) begin
			bad_count = bad_count + 1;
			give_verdict;
		end
	end
	// Startup count must pause while the clock line is held low
	task t_boot;
		begin
			mst.pull_clock(1'b1);
			repeat (40) @(negedge clk_sys_in);
			chk(ready, 0);
			mst.pull_clock(1'b0);
			repeat (10) @(negedge clk_sys_in);
			chk(ready, 0);
			repeat (20) @(negedge clk_sys_in);
			chk({ready, sleep}, 2'b11);
			// A measurement alone keeps it awake, and no stretch while unaddressed
			measuring_in = 1;
			repeat (3) @(negedge clk_sys_in);
			chk({sleep, scl}, 2'b01);
			measuring_in = 0;
			repeat (3) @(negedge clk_sys_in);
			chk(sleep, 1);
		end
	endtask
	task t_wr;
		begin
			mst.start;
			chk({busy, sleep}, 2'b10);
			mst.xbyte(9'h129, q);
			chk({q[0], match, rmode}, 3'b010);
			mst.xbyte(9'h14b, q);
			chk({q[0], rx_data}, 9'h0a5);
			mst.xbyte(9'h079, q);
			chk({q[0], rx_data}, 9'h03c);
			mst.stop;
			chk({busy, match}, 2'b00);
		end
	endtask
	task t_rd;
		begin
			tx_data_in = 8'hc3;
			mst.start;
			mst.xbyte(9'h12b, q);
			chk({q[0], match, rmode}, 3'b011);
			mst.xbyte(9'h1fe, q);
			tx_data_in = 8'h5a;
			chk(q[8:1], 9'h0c3);
			mst.xbyte(9'h1ff, q);
			chk(q[8:1], 9'h05a);
			mst.stop;
			chk({1'b0, taken_count[3:0], nack_count[3:0]}, 9'h021);
		end
	endtask
	task t_bad;
		integer i;
		begin
			for (i = 0; i < 2; i = i + 1) begin
				mst.start;
				mst.xbyte(i ? 9'h12d : 9'h029, q);
				chk({q[0], match}, 2'b10);
				mst.stop;
			end
		end
	endtask
	// Stretch during a byte, then a repeated start
	task t_hold;
		begin
			mst.start;
			mst.xbyte(9'h129, q);
			measuring_in = 1;
			t0 = $time;
			fork
				begin
					repeat (300) @(negedge clk_sys_in);
					chk({sleep, scl, scl_o, sda_o}, 4'h0);
					measuring_in = 0;
				end
				mst.xbyte(9'h1ff, q);
			join
			chk(($time - t0) > 3000, 1);
			chk({q[0], rx_data}, 9'h0ff);
			mst.start;
			mst.xbyte(9'h12b, q);
			chk({q[0], busy, rmode}, 3'b011);
			mst.xbyte(9'h1ff, q);
			chk(q[8:1], 9'h05a);
			mst.stop;
			chk({busy, match}, 2'b00);
		end
	endtask
	initial begin
		repeat (16) @(negedge clk_sys_in);
		reset_n_in = 1;
		t_boot;
		t_wr;
		t_rd;
		t_bad;
		t_hold;
		give_verdict;
	end
endmodule // sensor_i2c_target_bus_layer_tb_top
